// ===== logic/file_move_rotate_control.v
// controller for move-file, store-work, nop and rotate-left instructions
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
module file_move_rotate_control (
    // clock and reset
    input  wire        mclk_i,
    input  wire        reset_n_i,
    // apb slave
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [7:0]  paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    // program store and datapath inputs
    input  wire [11:0] prog_word_i,
    input  wire [7:0]  sfr_data_i,
    input  wire [7:0]  ram_data_i,
    input  wire [7:0]  work_reg_i,
    input  wire        carry_i,
    // sequencing
    output reg         instr_reg_capture_o,
    output reg         pc_advance_o,
    // address and operand selects
    output reg         alu_mux_sel_o,
    output reg         reg_addr_mux_sel_o,
    output reg  [4:0]  direct_addr_o,
    // result targets and flag strobes
    output reg         load_work_reg_o,
    output reg         load_file_reg_o,
    output reg         load_z_o,
    output reg         load_c_o,
    output reg         load_dc_o,
    // alu
    output reg  [1:0]  alu_op_o,
    output wire [7:0]  alu_bus_o,
    output wire        alu_carry_o,
    output wire        alu_zero_o
);
`include "file_move_rotate_regs.vh"

    // instruction register and control state
    reg  [11:0] instr_reg_q;
    reg  [2:0]  class_q;
    reg  [2:0]  class_d;
    reg         run_q;
    reg         step_req_q;
    reg         step_ack_q;
    reg         unsup_q;
    reg  [15:0] total_q;
    wire [31:0] class_count_w;

    // decode wires
    wire [4:0]  file_fld;
    wire        dest_bit;
    wire        is_move;
    wire        is_store;
    wire        is_nop;
    wire        is_rotate;
    wire        step_pending;
    wire        issue;

    // next values of the falling-edge controls
    reg         capture_d;
    reg         advance_d;
    reg         mux_sel_d;
    reg         addr_sel_d;
    reg  [4:0]  direct_d;
    reg         load_w_d;
    reg         load_f_d;
    reg         load_z_d;
    reg         load_c_d;
    reg  [1:0]  alu_op_d;

    assign file_fld  = instr_reg_q[`FLD_FILE_HI:`FLD_FILE_LO];
    assign dest_bit  = instr_reg_q[`FLD_DEST_BIT];
    assign is_move   = (instr_reg_q & `OPC_MASK_DF) == `OPC_MOVE_FILE;
    assign is_rotate = (instr_reg_q & `OPC_MASK_DF) == `OPC_ROTATE_LEFT;
    assign is_store  = (instr_reg_q & `OPC_MASK_STORE) == `OPC_STORE_WORK;
    assign is_nop    = instr_reg_q == `OPC_NOP;

    // a step request is a toggle so each side keeps its own flop
    assign step_pending = step_req_q ^ step_ack_q;
    assign issue        = run_q | step_pending;

    // decode of the instruction held since the last rising edge
    always @* begin
        capture_d  = 1'b0;
        advance_d  = 1'b0;
        mux_sel_d  = 1'b0;
        addr_sel_d = 1'b0;
        direct_d   = 5'h00;
        load_w_d   = 1'b0;
        load_f_d   = 1'b0;
        load_z_d   = 1'b0;
        load_c_d   = 1'b0;
        alu_op_d   = `ALU_IDLE;
        class_d    = `CLS_NONE;
        if (issue) begin
            // every instruction here finishes in one cycle
            capture_d = 1'b1;
            advance_d = 1'b1;
            if (is_move || is_store || is_rotate) begin
                mux_sel_d  = file_fld < `FILE_SFR_LIMIT;
                addr_sel_d = file_fld == `FILE_INDIRECT;
                direct_d   = file_fld;
            end
            if (is_move) begin
                class_d  = `CLS_MOVE_FILE;
                alu_op_d = `ALU_PASS_OPERAND;
                load_w_d = ~dest_bit;
                load_f_d = dest_bit;
                load_z_d = 1'b1;
            end else if (is_store) begin
                class_d  = `CLS_STORE_WORK;
                alu_op_d = `ALU_PASS_WORK;
                load_f_d = 1'b1;
                load_z_d = 1'b1;
            end else if (is_rotate) begin
                class_d  = `CLS_ROTATE_LEFT;
                alu_op_d = `ALU_ROTATE_LEFT;
                load_w_d = ~dest_bit;
                load_f_d = dest_bit;
                load_c_d = 1'b1;
            end else if (is_nop) begin
                class_d = `CLS_NOP;
            end else begin
                // other opcodes belong to sibling decoders; just move on
                class_d = `CLS_UNSUPPORTED;
            end
        end
    end

    // setup on the falling edge so selects settle before the write edge
    always @(negedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            instr_reg_capture_o <= 1'b0;
            pc_advance_o        <= 1'b0;
            alu_mux_sel_o       <= 1'b0;
            reg_addr_mux_sel_o  <= 1'b0;
            direct_addr_o       <= 5'h00;
            load_work_reg_o     <= 1'b0;
            load_file_reg_o     <= 1'b0;
            load_z_o            <= 1'b0;
            load_c_o            <= 1'b0;
            load_dc_o           <= 1'b0;
            alu_op_o            <= `ALU_IDLE;
            class_q             <= `CLS_NONE;
            step_ack_q          <= 1'b0;
        end else begin
            instr_reg_capture_o <= capture_d;
            pc_advance_o        <= advance_d;
            alu_mux_sel_o       <= mux_sel_d;
            reg_addr_mux_sel_o  <= addr_sel_d;
            direct_addr_o       <= direct_d;
            load_work_reg_o     <= load_w_d;
            load_file_reg_o     <= load_f_d;
            load_z_o            <= load_z_d;
            load_c_o            <= load_c_d;
            // no instruction here touches digit carry
            load_dc_o           <= 1'b0;
            alu_op_o            <= alu_op_d;
            class_q             <= class_d;
            if (!run_q && step_pending) begin
                step_ack_q <= ~step_ack_q;
            end
        end
    end

    // next word is taken on the rising edge the capture strobe covers
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            instr_reg_q <= `INSTR_RESET;
        end else if (instr_reg_capture_o) begin
            instr_reg_q <= prog_word_i;
        end
    end

    // operand mux and alu; result is combinational because the file
    // data only settles after the falling-edge address setup
    rotate_alu_slice u_alu (
        .alu_op_i   (alu_op_o),
        .operand_i  (alu_mux_sel_o ? sfr_data_i : ram_data_i),
        .work_reg_i (work_reg_i),
        .carry_i    (carry_i),
        .result_o   (alu_bus_o),
        .carry_o    (alu_carry_o),
        .zero_o     (alu_zero_o)
    );

    // execution counters for the move, store, nop and rotate classes, one byte each
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_COUNTED; gi = gi + 1) begin : g_cnt
            reg [7:0] cnt_q;
            always @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cnt_q <= 8'h00;
                end else if (instr_reg_capture_o && class_q == gi + 1) begin
                    cnt_q <= cnt_q + 8'h01;
                end
            end
            assign class_count_w[gi*8 +: 8] = cnt_q;
        end
    endgenerate

    // apb access phase decode
    wire        setup_ph;
    wire        wr_acc;
    wire        addr_ok;
    reg  [31:0] rd_d;

    assign setup_ph = psel_i & ~penable_i;
    assign wr_acc   = psel_i & penable_i & pwrite_i & pready_o;
    assign addr_ok  = (paddr_i == `REG_CTRL) || (paddr_i == `REG_STATUS) ||
                      (paddr_i == `REG_CLASS_COUNT) || (paddr_i == `REG_TOTAL_COUNT);

    always @* begin
        rd_d = 32'h0000_0000;
        case (paddr_i)
            `REG_CTRL: begin
                rd_d[`CTRL_RUN_BIT] = run_q;
            end
            `REG_STATUS: begin
                rd_d[11:0]                         = instr_reg_q;
                rd_d[`STAT_CLASS_LO +: 3]          = class_q;
                rd_d[`STAT_UNSUP_BIT]              = unsup_q;
                rd_d[`STAT_RUN_BIT]                = run_q;
            end
            `REG_CLASS_COUNT: begin
                rd_d = class_count_w;
            end
            `REG_TOTAL_COUNT: begin
                rd_d[15:0] = total_q;
            end
            default: begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    // zero wait states: answer is staged in the setup cycle
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prdata_o  <= 32'h0000_0000;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o <= 1'b1;
            if (setup_ph) begin
                prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_d;
                pslverr_o <= ~addr_ok;
            end
        end
    end

    // software control and sticky status
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            run_q      <= `CTRL_RUN_RESET;
            step_req_q <= 1'b0;
            unsup_q    <= 1'b0;
            total_q    <= 16'h0000;
        end else begin
            if (wr_acc && paddr_i == `REG_CTRL) begin
                run_q <= pwdata_i[`CTRL_RUN_BIT];
                // a step already in flight is not stacked
                if (pwdata_i[`CTRL_STEP_BIT] && !step_pending) begin
                    step_req_q <= ~step_req_q;
                end
            end
            // a new unsupported opcode wins over a same-cycle clear
            if (instr_reg_capture_o && class_q == `CLS_UNSUPPORTED) begin
                unsup_q <= 1'b1;
            end else if (wr_acc && paddr_i == `REG_STATUS && pwdata_i[`STAT_UNSUP_BIT]) begin
                unsup_q <= 1'b0;
            end
            if (instr_reg_capture_o) begin
                total_q <= total_q + 16'h0001;
            end
        end
    end

endmodule // file_move_rotate_control

// ===== logic/file_move_rotate_regs.vh
// constants for the move, store, nop and rotate controller
`ifndef FILE_MOVE_ROTATE_REGS_VH
`define FILE_MOVE_ROTATE_REGS_VH

// opcode patterns, compared under mask against the 12-bit word; nop is compared whole
`define OPC_MASK_DF        12'hFC0
`define OPC_MOVE_FILE      12'h200
`define OPC_ROTATE_LEFT    12'h340
`define OPC_MASK_STORE     12'hFE0
`define OPC_STORE_WORK     12'h020
`define OPC_NOP            12'h000

// instruction word fields
`define FLD_DEST_BIT       5
`define FLD_FILE_HI        4
`define FLD_FILE_LO        0
`define FILE_INDIRECT      5'h00
`define FILE_SFR_LIMIT     5'h08

// alu operations
`define ALU_PASS_OPERAND   2'h0
`define ALU_PASS_WORK      2'h1
`define ALU_ROTATE_LEFT    2'h2
`define ALU_IDLE           2'h3

// decoded instruction classes
`define CLS_NONE           3'h0
`define CLS_MOVE_FILE      3'h1
`define CLS_STORE_WORK     3'h2
`define CLS_NOP            3'h3
`define CLS_ROTATE_LEFT    3'h4
`define CLS_UNSUPPORTED    3'h5

// apb register byte offsets
`define REG_CTRL           8'h00
`define REG_STATUS         8'h04
`define REG_CLASS_COUNT    8'h08
`define REG_TOTAL_COUNT    8'h0C

// field positions
`define CTRL_RUN_BIT       0
`define CTRL_STEP_BIT      1
`define STAT_CLASS_LO      12
`define STAT_UNSUP_BIT     16
`define STAT_RUN_BIT       17

// reset values and number of counted classes
`define CTRL_RUN_RESET     1'b1
`define INSTR_RESET        12'h000
`define NUM_COUNTED        4
`endif

// ===== logic/rotate_alu_slice.v
// alu slice for pass, store and rotate-left through carry
`timescale 1ns/10ps
module rotate_alu_slice (
    // operation
    input  wire [1:0] alu_op_i,
    // operands
    input  wire [7:0] operand_i,
    input  wire [7:0] work_reg_i,
    input  wire       carry_i,
    // result
    output reg  [7:0] result_o,
    output reg        carry_o,
    output wire       zero_o
);
`include "file_move_rotate_regs.vh"

    always @* begin
        result_o = 8'h00;
        carry_o  = carry_i;
        case (alu_op_i)
            `ALU_PASS_OPERAND: begin
                result_o = operand_i;
            end
            `ALU_PASS_WORK: begin
                result_o = work_reg_i;
            end
            `ALU_ROTATE_LEFT: begin
                {carry_o, result_o} = {operand_i, carry_i};
            end
            default: begin
                result_o = 8'h00;
            end
        endcase
    end

    assign zero_o = (result_o == 8'h00);

endmodule // rotate_alu_slice

// ===== testbench/core_datapath_model.sv
// datapath partner: work register, carry and file store
`timescale 1ns/10ps
module core_datapath_model (
    // clock and controls
    input  wire logic       mclk_i,
    input  wire logic       reg_addr_mux_sel_i,
    input  wire logic [4:0] direct_addr_i,
    input  wire logic       load_work_reg_i,
    input  wire logic       load_file_reg_i,
    input  wire logic       load_c_i,
    input  wire logic [7:0] alu_bus_i,
    input  wire logic       alu_carry_i,
    // operands back to the controller
    output logic [7:0]      sfr_data_o,
    output logic [7:0]      ram_data_o,
    output logic [7:0]      work_reg_o,
    output logic            carry_o
);
    logic [4:0] indirect_pointer_reg = 5'h0D;
    logic [7:0] file_q [32];
    wire  [4:0] addr = reg_addr_mux_sel_i ? indirect_pointer_reg : direct_addr_i;
    assign sfr_data_o = file_q[addr];
    // ram side differs so a wrong operand select shows on the bus
    assign ram_data_o = file_q[addr] ^ 8'hA5;
    initial begin
        for (int i = 0; i < 32; i++) file_q[i] = 8'(i * 37);
        work_reg_o = 8'h5A;
        carry_o = 1'b1;
    end
    always @(posedge mclk_i) begin
        if (load_work_reg_i) work_reg_o <= alu_bus_i;
        if (load_file_reg_i) file_q[addr] <= alu_bus_i;
        if (load_c_i) carry_o <= alu_carry_i;
    end
endmodule // core_datapath_model

// ===== testbench/file_move_rotate_control_checker.sv
// port assertions for the move, store, nop and rotate controller
`timescale 1ns/10ps
`include "file_move_rotate_regs.vh"
module file_move_rotate_control_checker (
    // clock, reset and inputs
    input logic        mclk_i,
    input logic        reset_n_i,
    input logic [11:0] prog_word_i,
    input logic [7:0]  sfr_data_i,
    input logic [7:0]  ram_data_i,
    input logic        carry_i,
    // controller outputs
    input logic        instr_reg_capture_o,
    input logic        pc_advance_o,
    input logic        alu_mux_sel_o,
    input logic        reg_addr_mux_sel_o,
    input logic [4:0]  direct_addr_o,
    input logic        load_work_reg_o,
    input logic        load_file_reg_o,
    input logic        load_z_o,
    input logic        load_c_o,
    input logic        load_dc_o,
    input logic [1:0]  alu_op_o,
    input logic [7:0]  alu_bus_o,
    input logic        alu_carry_o,
    input logic        alu_zero_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    wire [11:0] w   = prog_word_i;
    wire        mv  = (w & `OPC_MASK_DF) == `OPC_MOVE_FILE;
    wire        rl  = (w & `OPC_MASK_DF) == `OPC_ROTATE_LEFT;
    wire        st  = (w & `OPC_MASK_STORE) == `OPC_STORE_WORK;
    wire [7:0]  opd = alu_mux_sel_o ? sfr_data_i : ram_data_i;
    // a word counts once taken and then issued; a stopped core holds it
    sequence take_s(c);
        instr_reg_capture_o && c ##1 instr_reg_capture_o;
    endsequence
    move_dest_a: assert property (take_s(mv) |-> load_z_o && !load_c_o && !load_dc_o
        && load_file_reg_o == $past(w[5]) && load_work_reg_o != $past(w[5]) && alu_op_o == `ALU_PASS_OPERAND)
        else $error("move targets or flags wrong");
    store_target_a: assert property (take_s(st) |-> load_file_reg_o && !load_work_reg_o && load_z_o
        && !load_c_o && alu_op_o == `ALU_PASS_WORK) else $error("store targets or flags wrong");
    rotate_dest_a: assert property (take_s(rl) |-> load_c_o && !load_z_o && !load_dc_o
        && load_file_reg_o == $past(w[5]) && alu_op_o == `ALU_ROTATE_LEFT) else $error("rotate targets wrong");
    nop_quiet_a: assert property (take_s(w == `OPC_NOP) |-> !(load_work_reg_o | load_file_reg_o | load_z_o
        | load_c_o | load_dc_o)) else $error("nop drove a load");
    addr_select_a: assert property (take_s(mv | rl | st) |-> direct_addr_o == $past(w[4:0])
        && reg_addr_mux_sel_o == ($past(w[4:0]) == `FILE_INDIRECT)) else $error("file address select wrong");
    operand_sel_a: assert property (take_s(mv | rl | st) |-> alu_mux_sel_o == ($past(w[4:0]) < `FILE_SFR_LIMIT))
        else $error("operand source wrong");
    issue_pair_a: assert property (instr_reg_capture_o == pc_advance_o) else $error("capture and advance differ");
    rotate_alu_a: assert property (alu_op_o == `ALU_ROTATE_LEFT |-> {alu_carry_o, alu_bus_o} == {opd, carry_i})
        else $error("rotate result wrong");
    pass_alu_a: assert property (alu_op_o == `ALU_PASS_OPERAND |-> alu_bus_o == opd && alu_zero_o == (opd == 8'h00))
        else $error("pass result wrong");
endmodule // file_move_rotate_control_checker

bind file_move_rotate_control file_move_rotate_control_checker i_chk (.mclk_i, .reset_n_i, .prog_word_i, .sfr_data_i,
    .ram_data_i, .carry_i, .instr_reg_capture_o, .pc_advance_o, .alu_mux_sel_o, .reg_addr_mux_sel_o, .direct_addr_o,
    .load_work_reg_o, .load_file_reg_o, .load_z_o, .load_c_o, .load_dc_o, .alu_op_o, .alu_bus_o, .alu_carry_o,
    .alu_zero_o);

// ===== testbench/file_move_rotate_control_test.sv
// self-checking bench for the move, store, nop and rotate controller
`timescale 1ns/10ps
`include "file_move_rotate_regs.vh"
`define CHK(g, e, m) begin compares++; if ((g) !== (e)) begin n_fail++; $display("mismatch %0t %s", $time, m); end end
module file_move_rotate_control_test;
    logic        mclk_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, err;
    logic [7:0]  paddr_i = 0, sfr_data_i, ram_data_i, work_reg_i, alu_bus_o;
    logic [31:0] pwdata_i = 0, prdata_o, rd, seed = 72;
    logic [11:0] prog_word_i = 0;
    logic [4:0]  direct_addr_o;
    logic [1:0]  alu_op_o;
    logic        pready_o, pslverr_o, carry_i, instr_reg_capture_o, pc_advance_o, alu_mux_sel_o, reg_addr_mux_sel_o;
    logic        load_work_reg_o, load_file_reg_o, load_z_o, load_c_o, load_dc_o, alu_carry_o, alu_zero_o;
    int          n_fail = 0, compares = 0, cyc = 0, n_mv = 0, n_st = 0, n_rl = 0, caps;
    logic [11:0] dir [8] = '{12'h220, 12'h207, 12'h028, 12'h020, 12'h340, 12'h368, 12'h000, 12'hFFF};
    typedef struct { int due; logic [15:0] e, m; } note_t;
    note_t q[$];
    wire [15:0] got = {instr_reg_capture_o, pc_advance_o, load_work_reg_o, load_file_reg_o, load_z_o, load_c_o,
                       load_dc_o, alu_mux_sel_o, reg_addr_mux_sel_o, direct_addr_o, alu_op_o};
    file_move_rotate_control i_file_move_rotate_control (.mclk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i,
        .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .prog_word_i, .sfr_data_i, .ram_data_i, .work_reg_i,
        .carry_i, .instr_reg_capture_o, .pc_advance_o, .alu_mux_sel_o, .reg_addr_mux_sel_o, .direct_addr_o,
        .load_work_reg_o, .load_file_reg_o, .load_z_o, .load_c_o, .load_dc_o, .alu_op_o, .alu_bus_o, .alu_carry_o,
        .alu_zero_o);
    core_datapath_model i_core_datapath_model (.mclk_i, .reg_addr_mux_sel_i(reg_addr_mux_sel_o),
        .direct_addr_i(direct_addr_o), .load_work_reg_i(load_work_reg_o), .load_file_reg_i(load_file_reg_o),
        .load_c_i(load_c_o), .alu_bus_i(alu_bus_o), .alu_carry_i(alu_carry_o), .sfr_data_o(sfr_data_i),
        .ram_data_o(ram_data_i), .work_reg_o(work_reg_i), .carry_o(carry_i));
    initial forever #50 mclk_i = ~mclk_i;
    // counted on the falling edge so the driver reads a settled value
    always @(negedge mclk_i) cyc++;
    always @(posedge mclk_i) begin
        if (q.size() > 0 && q[0].due == cyc) begin
            `CHK(got & q[0].m, q[0].e, "control set")
            void'(q.pop_front());
        end
    end
    function automatic logic [11:0] rnd_word();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        case (seed[1:0])
            0: return `OPC_MOVE_FILE | seed[17:12];
            1: return `OPC_STORE_WORK | seed[16:12];
            2: return `OPC_ROTATE_LEFT | seed[17:12];
            default: return `OPC_NOP;
        endcase
    endfunction
    task automatic issue(input logic [11:0] w);
        logic [4:0] f;
        logic [15:0] e, m;
        f = w[4:0];
        m = 16'hFFFF;
        e = {2'b11, 5'b00000, f < `FILE_SFR_LIMIT, f == `FILE_INDIRECT, f, 2'h0};
        if ((w & `OPC_MASK_DF) == `OPC_MOVE_FILE) begin
            e[13:11] = {~w[5], w[5], 1'b1};
            n_mv++;
        end else if ((w & `OPC_MASK_DF) == `OPC_ROTATE_LEFT) begin
            e[13:10] = {~w[5], w[5], 2'b01};
            e[1:0] = `ALU_ROTATE_LEFT;
            n_rl++;
        end else if ((w & `OPC_MASK_STORE) == `OPC_STORE_WORK) begin
            e[13:11] = 3'b011;
            e[1:0] = `ALU_PASS_WORK;
            n_st++;
        end else begin
            e = 16'hC000;
            m = 16'hFE00;
        end
        @(posedge mclk_i);
        prog_word_i <= w;
        q.push_back('{cyc + 2, e & m, m});
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge mclk_i);
        psel_i <= 1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge mclk_i);
        penable_i <= 1;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (pready_o !== 1'b1 && k < 20);
        if (k == 20) begin
            n_fail++;
            tally_and_finish();
        end
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 0;
        penable_i <= 0;
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge mclk_i);
        reset_n_i <= 1;
        foreach (dir[i]) issue(dir[i]);
        repeat (60) issue(rnd_word());
        issue(`OPC_NOP);
        repeat (3) @(posedge mclk_i);
        $display("decode test done");
        apb(0, `REG_CTRL, 0);
        `CHK(rd, 32'h1, "control reset value")
        apb(0, `REG_CLASS_COUNT, 0);
        `CHK({rd[31:24], rd[15:0]}, {n_rl[7:0], n_st[7:0], n_mv[7:0]}, "class counts")
        apb(0, `REG_STATUS, 0);
        `CHK(rd[`STAT_UNSUP_BIT], 1'b1, "unsupported flag")
        apb(0, 8'h10, 0);
        `CHK({err, rd}, {1'b1, 32'h0}, "unmapped read")
        $display("register test done");
        apb(1, `REG_CTRL, 0);
        prog_word_i <= `OPC_MOVE_FILE | 12'h02A;
        caps = 0;
        repeat (8) @(posedge mclk_i) caps += instr_reg_capture_o + pc_advance_o;
        `CHK(caps, 0, "stopped core issued")
        apb(1, `REG_CTRL, 32'h2);
        repeat (8) @(posedge mclk_i) caps += instr_reg_capture_o + pc_advance_o;
        `CHK(caps, 2, "single step count")
        apb(1, `REG_CTRL, 32'h1);
        prog_word_i <= `OPC_NOP;
        $display("step test done");
        tally_and_finish();
    end
endmodule // file_move_rotate_control_test
